// ===== csr_access_if.sv
// word access path between the indirect port and the register file
`timescale 1ns/1ps
`default_nettype none
interface csr_access_if;
    logic wr_en;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport port (output wr_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : csr_access_if
`default_nettype wire

// ===== csr_cfg_pkg.sv
// constants for the mac configuration register bank
package csr_cfg_pkg;
    // indirect port commands, low four bits of the command register
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE = 4'h8;
    localparam logic [3:0] CMD_READ = 4'h9;
    localparam int BUSY_BIT = 7;
    // register addresses
    localparam logic [7:0] ADDR_MAC_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATION_HIGH = 8'h04;
    localparam logic [7:0] ADDR_STATION_LOW = 8'h08;
    // reset values and writable masks
    localparam logic [31:0] MAC_CONTROL_RESET = 32'h0004_0000;
    localparam logic [31:0] MAC_CONTROL_MASK = 32'hD8FF_BDEC;
    localparam logic [31:0] STATION_HIGH_RESET = 32'h0000_FFFF;
    localparam logic [31:0] STATION_HIGH_MASK = 32'h0000_FFFF;
    localparam logic [31:0] STATION_LOW_RESET = 32'hFFFF_FFFF;
    // mac control field positions
    localparam int F_RECEIVE_ALL = 31;
    localparam int F_BYTE_ORDER = 30;
    localparam int F_HEARTBEAT_DIS = 28;
    localparam int F_PORT_SELECT = 27;
    localparam int F_RX_OWN_DIS = 23;
    localparam int F_LOOPBACK_HI = 22;
    localparam int F_LOOPBACK_LO = 21;
    localparam int F_FULL_DUPLEX = 20;
    localparam int F_PASS_MCAST = 19;
    localparam int F_PROMISCUOUS = 18;
    localparam int F_INVERSE = 17;
    localparam int F_PASS_BAD = 16;
    localparam int F_HASH_ONLY = 15;
    localparam int F_HASH_PERFECT = 13;
    localparam int F_LATE_COLL = 12;
    localparam int F_BCAST_DIS = 11;
    localparam int F_RETRY_DIS = 10;
    localparam int F_PAD_STRIP = 8;
    localparam int F_BACKOFF_HI = 7;
    localparam int F_BACKOFF_LO = 6;
    localparam int F_DEFERRAL = 5;
    localparam int F_TX_ENABLE = 3;
    localparam int F_RX_ENABLE = 2;
    // loopback codes
    localparam logic [1:0] LOOP_NORMAL = 2'h0;
    localparam logic [1:0] LOOP_INTERNAL = 2'h1;
    localparam logic [1:0] LOOP_EXTERNAL = 2'h2;
    // transmit policy
    localparam logic [4:0] ATTEMPTS_NORMAL = 5'h10;
    localparam logic [4:0] ATTEMPTS_NO_RETRY = 5'h01;
    localparam int SLOT_BITS = 512;
    localparam int DEFER_LIMIT_BITS = 24288;
    localparam int PAD_MIN_LENGTH = 46;
endpackage : csr_cfg_pkg

// ===== csr_cfg_regs.sv
// mac control and station address register file
`timescale 1ns/1ps
`default_nettype none
module csr_cfg_regs
    import csr_cfg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // word access
    csr_access_if.regs acc,
    // register contents
    output logic [31:0] mac_control,
    output logic [47:0] station_address
);
    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] high_reg, high_next;
    logic [31:0] low_reg, low_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        high_next = high_reg;
        low_next = low_reg;
        if (acc.wr_en) begin
            case (acc.addr)
                // unused bits ignore writes
                ADDR_MAC_CONTROL: ctrl_next = acc.wdata & MAC_CONTROL_MASK;
                ADDR_STATION_HIGH: high_next = acc.wdata[15:0];
                ADDR_STATION_LOW: low_next = acc.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= MAC_CONTROL_RESET;
            high_reg <= STATION_HIGH_RESET[15:0];
            low_reg <= STATION_LOW_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            high_reg <= high_next;
            low_reg <= low_next;
        end
    end

    always_comb begin
        case (acc.addr)
            ADDR_MAC_CONTROL: acc.rdata = ctrl_reg;
            ADDR_STATION_HIGH: acc.rdata = {16'h0000, high_reg};
            ADDR_STATION_LOW: acc.rdata = low_reg;
            default: acc.rdata = 32'h0000_0000;
        endcase
    end

    assign mac_control = ctrl_reg;
    assign station_address = {high_reg, low_reg};
endmodule : csr_cfg_regs
`default_nettype wire

// ===== ethernet_mac_csr_config.sv
// indirect register port and decoded mac configuration outputs
// What this block does
// - read: address, command 1001b, wait busy bit 7 clear, unload four bytes.
// - indirectly reached registers are 32 bits wide, except station high: 16 bits, upper half reads zero.
// - receive-all passes error-free frames with filter bit set, beats flushing.
// - byte order bit: little-endian when clear, big-endian when set.
// - port select: mii or serial codec; heartbeat disable only in codec mode.
// - receive-own disable blocks reception while own transmit enable is high.
// - loopback field: normal, internal, external; code 11 reserved.
// - duplex bit: half duplex when clear, full duplex when set.
// - pass-all-multicast accepts all multicast and clears filter fail.
// - promiscuous resets set; clearing it restores address filtering.
// - inverse filtering inverts the address check decision for all but broadcast frames.
// - pass-bad-frames flags filter-passing frames even with errors.
// - hash bits pick perfect, multicast hash, or hash for both.
// - late collision: abort when clear, keep retrying when set.
// - broadcast disable clears filter bit for broadcasts (not under receive-all), else set.
// - retry disable: one attempt, else sixteen, before retry error.
// - pad strip removes pad and crc when length field below 46.
// - backoff from free 10-bit slot counter masked to 10, 8, 4 or 1 bits.
// - deferral check aborts after more than 24,288 bit times deferring.
// - transmitter and receiver run only while enabled; both reset clear.
// - 48-bit station address split high 16 / low 32, resets to ones.
`timescale 1ns/1ps
`default_nettype none
module ethernet_mac_csr_config
    import csr_cfg_pkg::*;
#(
    parameter int READ_LATENCY = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // cpu side indirect port
    input wire logic buffer_command_we,
    input wire logic [7:0] buffer_command_wdata,
    output logic [7:0] buffer_command_reg,
    input wire logic indirect_address_we,
    input wire logic [7:0] indirect_address_wdata,
    output logic [7:0] indirect_address_reg,
    input wire logic indirect_data_we,
    input wire logic indirect_data_re,
    input wire logic [7:0] indirect_data_wdata,
    output logic [7:0] indirect_data_reg,
    // frame filter inputs, one per received frame
    input wire logic rx_frame_done,
    input wire logic rx_frame_error,
    input wire logic rx_is_broadcast,
    input wire logic rx_is_multicast,
    input wire logic rx_perfect_hit,
    input wire logic rx_hash_hit,
    input wire logic [15:0] rx_length_field,
    input wire logic flush_filter_fail,
    // transmit side inputs
    input wire logic tx_en,
    input wire logic late_collision,
    input wire logic bit_time_tick,
    input wire logic deferring,
    // filter results
    output logic rx_packet_filter,
    output logic rx_frame_accept,
    output logic rx_strip_pad,
    // decoded configuration
    output logic big_endian,
    output logic codec_mode,
    output logic heartbeat_enable,
    output logic rx_blocked,
    output logic [1:0] loopback_select,
    output logic full_duplex,
    output logic tx_allowed,
    output logic rx_allowed,
    output logic late_collision_abort,
    output logic [4:0] attempt_limit,
    output logic [9:0] backoff_slots,
    output logic defer_abort,
    output logic [47:0] station_address
);
    typedef enum logic [1:0] {IDLE = 2'b00, READ_WAIT = 2'b01, READ_DONE = 2'b11} port_state_e;

    localparam logic [7:0] RD_LAT = 8'(READ_LATENCY);
    localparam logic [8:0] SLOT_COUNT = 9'(SLOT_BITS - 1);
    localparam logic [14:0] DEFER_COUNT = 15'(DEFER_LIMIT_BITS);

    csr_access_if acc ();
    logic [31:0] mac_control;

    port_state_e state_reg, state_next;
    logic [31:0] shift_reg, shift_next;
    logic [7:0] addr_reg, addr_next;
    logic [3:0] cmd_reg, cmd_next;
    logic [7:0] wait_reg, wait_next;
    logic [8:0] slot_bit_reg, slot_bit_next;
    logic [9:0] backoff_cnt_reg, backoff_cnt_next;
    logic [14:0] defer_reg, defer_next;
    logic [7:0] data_out_reg, data_out_next;
    logic pf_reg, pf_next, acc_reg, acc_next, strip_reg, strip_next;

    csr_cfg_regs u_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .acc(acc),
        .mac_control(mac_control),
        .station_address(station_address)
    );

    // one free counter serves every limit; the mask only narrows the draw
    function automatic logic [9:0] backoff_mask(input logic [1:0] code);
        case (code)
            2'h0: backoff_mask = 10'h3FF;
            2'h1: backoff_mask = 10'h0FF;
            2'h2: backoff_mask = 10'h00F;
            default: backoff_mask = 10'h001;
        endcase
    endfunction

    // indirect port state
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        cmd_next = cmd_reg;
        wait_next = wait_reg;
        acc.wr_en = 1'b0;
        acc.addr = addr_reg;
        acc.wdata = shift_reg;
        // data loads shift in msb first
        if (indirect_data_we) begin
            shift_next = {shift_reg[23:0], indirect_data_wdata};
        end else if (indirect_data_re && state_reg != READ_WAIT) begin
            shift_next = {shift_reg[23:0], 8'h00};
        end
        if (indirect_address_we) begin
            addr_next = indirect_address_wdata;
        end
        case (state_reg)
            IDLE, READ_DONE: begin
                if (buffer_command_we) begin
                    cmd_next = buffer_command_wdata[3:0];
                    if (buffer_command_wdata[3:0] == CMD_WRITE) begin
                        acc.wr_en = 1'b1;
                        state_next = IDLE;
                    end else if (buffer_command_wdata[3:0] == CMD_READ) begin
                        wait_next = RD_LAT;
                        state_next = READ_WAIT;
                    end
                end
            end
            READ_WAIT: begin
                // commands while busy are ignored
                // register file answers at once; the wait models the access time
                if (wait_reg == 8'h00) begin
                    shift_next = acc.rdata;
                    state_next = READ_DONE;
                end else begin
                    wait_next = wait_reg - 8'h01;
                end
            end
            default: state_next = IDLE;
        endcase
        data_out_next = shift_next[31:24];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= IDLE;
            shift_reg <= 32'h0000_0000;
            addr_reg <= 8'h00;
            cmd_reg <= CMD_NOP;
            wait_reg <= 8'h00;
            data_out_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            cmd_reg <= cmd_next;
            wait_reg <= wait_next;
            data_out_reg <= data_out_next;
        end
    end

    assign buffer_command_reg = {state_reg == READ_WAIT, 3'h0, cmd_reg};
    assign indirect_address_reg = addr_reg;
    assign indirect_data_reg = data_out_reg;

    // frame filter decision, registered one cycle after frame done
    // results are held between frames so the status word stays readable
    always_comb begin
        logic dest_ok;
        logic hash_mc;
        logic hash_uc;
        dest_ok = 1'b0;
        hash_mc = mac_control[F_HASH_PERFECT];
        hash_uc = mac_control[F_HASH_PERFECT] & mac_control[F_HASH_ONLY];
        if (rx_is_broadcast) begin
            dest_ok = !mac_control[F_BCAST_DIS];
        end else if (rx_is_multicast) begin
            dest_ok = hash_mc ? rx_hash_hit : rx_perfect_hit;
        end else begin
            dest_ok = hash_uc ? rx_hash_hit : rx_perfect_hit;
        end
        if (mac_control[F_INVERSE] && !rx_is_broadcast) begin
            dest_ok = !dest_ok;
        end
        if (rx_is_multicast && !rx_is_broadcast && mac_control[F_PASS_MCAST]) begin
            dest_ok = 1'b1;
        end
        if (mac_control[F_PROMISCUOUS]) begin
            dest_ok = 1'b1;
        end
        // broadcast disable wins even over promiscuous mode
        if (rx_is_broadcast && mac_control[F_BCAST_DIS]) begin
            dest_ok = 1'b0;
        end
        pf_next = dest_ok && (!rx_frame_error || mac_control[F_PASS_BAD]);
        if (mac_control[F_RECEIVE_ALL] && !rx_frame_error) begin
            pf_next = 1'b1;
        end
        // flushing drops failed frames unless receive-all overrides it
        acc_next = pf_next || !flush_filter_fail || mac_control[F_RECEIVE_ALL];
        strip_next = mac_control[F_PAD_STRIP] && (rx_length_field < 16'(PAD_MIN_LENGTH));
        if (!rx_frame_done) begin
            pf_next = pf_reg;
            acc_next = acc_reg;
            strip_next = strip_reg;
        end
    end

    // carrier deferral comes from the phy side, so it is resynchronised first
    logic defer_meta_reg, defer_meta_next, defer_sync_reg, defer_sync_next;
    always_comb begin
        defer_meta_next = deferring;
        defer_sync_next = defer_meta_reg;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            defer_meta_reg <= 1'b0;
            defer_sync_reg <= 1'b0;
        end else begin
            defer_meta_reg <= defer_meta_next;
            defer_sync_reg <= defer_sync_next;
        end
    end

    // slot and deferral timers on the bit time enable
    // saturating one past the limit keeps the abort standing while deferral lasts
    always_comb begin
        slot_bit_next = slot_bit_reg;
        backoff_cnt_next = backoff_cnt_reg;
        defer_next = defer_reg;
        if (bit_time_tick) begin
            slot_bit_next = (slot_bit_reg == SLOT_COUNT) ? 9'h000 : slot_bit_reg + 9'h001;
            if (slot_bit_reg == SLOT_COUNT) begin
                backoff_cnt_next = backoff_cnt_reg + 10'h001;
            end
        end
        if (!defer_sync_reg) begin
            defer_next = 15'h0000;
        end else if (bit_time_tick && defer_reg <= DEFER_COUNT) begin
            defer_next = defer_reg + 15'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pf_reg <= 1'b0;
            acc_reg <= 1'b0;
            strip_reg <= 1'b0;
            slot_bit_reg <= 9'h000;
            backoff_cnt_reg <= 10'h000;
            defer_reg <= 15'h0000;
        end else begin
            pf_reg <= pf_next;
            acc_reg <= acc_next;
            strip_reg <= strip_next;
            slot_bit_reg <= slot_bit_next;
            backoff_cnt_reg <= backoff_cnt_next;
            defer_reg <= defer_next;
        end
    end

    assign rx_packet_filter = pf_reg;
    assign rx_frame_accept = acc_reg;
    assign rx_strip_pad = strip_reg;
    assign big_endian = mac_control[F_BYTE_ORDER];
    assign codec_mode = mac_control[F_PORT_SELECT];
    assign heartbeat_enable = !(mac_control[F_PORT_SELECT] && mac_control[F_HEARTBEAT_DIS]);
    assign rx_blocked = mac_control[F_RX_OWN_DIS] && tx_en;
    assign loopback_select = mac_control[F_LOOPBACK_HI:F_LOOPBACK_LO];
    assign full_duplex = mac_control[F_FULL_DUPLEX];
    assign tx_allowed = mac_control[F_TX_ENABLE];
    assign rx_allowed = mac_control[F_RX_ENABLE] && !rx_blocked;
    assign late_collision_abort = late_collision && !mac_control[F_LATE_COLL];
    assign attempt_limit = mac_control[F_RETRY_DIS] ? ATTEMPTS_NO_RETRY : ATTEMPTS_NORMAL;
    assign backoff_slots = backoff_cnt_reg
        & backoff_mask(mac_control[F_BACKOFF_HI:F_BACKOFF_LO]);
    assign defer_abort = mac_control[F_DEFERRAL] && (defer_reg > DEFER_COUNT);
endmodule : ethernet_mac_csr_config
`default_nettype wire

// ===== mac_csr_config_properties.sv
// concurrent checks on the indirect port and decoded outputs of the config bank
`timescale 1ns/1ps
`default_nettype none
module mac_csr_props
    import csr_cfg_pkg::*;
#(
    parameter int READ_LATENCY = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // indirect port
    input wire logic buffer_command_we,
    input wire logic [7:0] buffer_command_wdata,
    input wire logic [7:0] buffer_command_reg,
    input wire logic indirect_address_we,
    input wire logic [7:0] indirect_address_wdata,
    input wire logic [7:0] indirect_address_reg,
    input wire logic indirect_data_we,
    input wire logic indirect_data_re,
    input wire logic [7:0] indirect_data_reg,
    // filter and transmit side
    input wire logic rx_frame_done,
    input wire logic rx_packet_filter,
    input wire logic tx_en,
    input wire logic late_collision,
    input wire logic rx_blocked,
    input wire logic late_collision_abort,
    input wire logic codec_mode,
    input wire logic heartbeat_enable,
    input wire logic [4:0] attempt_limit
);
    logic busy;
    logic [7:0] busy_cnt_reg, busy_cnt_next;
    assign busy = buffer_command_reg[BUSY_BIT];
    // counts busy cycles so the read latency is checked without a long repetition
    always_comb begin
        busy_cnt_next = busy ? busy_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge sys_clk) begin
        busy_cnt_reg <= rst ? 8'h00 : busy_cnt_next;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_read_busy_len: assert property (!$past(rst) && $fell(busy) |-> busy_cnt_reg == READ_LATENCY + 1)
        else $error("busy length wrong");
    chk_busy_bound: assert property (busy_cnt_reg <= READ_LATENCY + 1)
        else $error("busy held too long");
    chk_read_start: assert property (buffer_command_we && !busy && buffer_command_wdata[3:0] == CMD_READ |=> busy)
        else $error("read did not start");
    chk_cmd_field: assert property (buffer_command_we && !busy |=> buffer_command_reg[3:0] == $past(buffer_command_wdata[3:0]))
        else $error("command field not loaded");
    chk_busy_refuse: assert property (busy && buffer_command_we |=> $stable(buffer_command_reg[3:0]))
        else $error("command taken while busy");
    chk_addr_load: assert property (indirect_address_we |=> indirect_address_reg == $past(indirect_address_wdata))
        else $error("address not loaded");
    chk_data_stands: assert property (!$past(rst) && !$past(indirect_data_we) && !$past(indirect_data_re) && !$fell(busy)
        |-> $stable(indirect_data_reg))
        else $error("data port changed unasked");
    chk_filter_stands: assert property (!$past(rst) && !$past(rx_frame_done) |-> $stable(rx_packet_filter))
        else $error("filter bit changed between frames");
    chk_own_block: assert property (rx_blocked |-> tx_en)
        else $error("receive blocked without transmit");
    chk_late_abort: assert property (late_collision_abort |-> late_collision)
        else $error("abort without late collision");
    chk_hb_mii: assert property (!codec_mode |-> heartbeat_enable)
        else $error("heartbeat off in mii mode");
    chk_attempt_val: assert property (attempt_limit == ATTEMPTS_NORMAL || attempt_limit == ATTEMPTS_NO_RETRY)
        else $error("attempt limit illegal");
    cov_read: cover property ($fell(busy));
    cov_frame: cover property (rx_frame_done && rx_packet_filter);
    cov_block: cover property (rx_blocked);
endmodule // mac_csr_props
bind ethernet_mac_csr_config mac_csr_props #(.READ_LATENCY(READ_LATENCY)) u_props (.sys_clk, .rst,
    .buffer_command_we, .buffer_command_wdata, .buffer_command_reg, .indirect_address_we,
    .indirect_address_wdata, .indirect_address_reg, .indirect_data_we, .indirect_data_re,
    .indirect_data_reg, .rx_frame_done, .rx_packet_filter, .tx_en, .late_collision, .rx_blocked,
    .late_collision_abort, .codec_mode, .heartbeat_enable, .attempt_limit);
`default_nettype wire

// ===== phy_model.sv
// behavioural physical-layer partner: bit timing, carrier deferral, late collisions
`timescale 1ns/1ps
`default_nettype none
module phy_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // scenario controls
    input wire logic carrier_busy,
    input wire logic coll_req,
    // toward the mac
    output logic bit_time_tick,
    output logic deferring,
    output logic late_collision
);
    // one bit time per clock keeps the long deferral count affordable
    assign bit_time_tick = !rst;
    assign deferring = !rst && carrier_busy;
    assign late_collision = !rst && coll_req;
endmodule // phy_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the mac configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; exp_v = (exp); if ((got) !== exp_v) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), exp_v); end end
module tb;
    import csr_cfg_pkg::*;
    localparam logic [31:0] RMASK [3] = '{MAC_CONTROL_MASK, STATION_HIGH_MASK, 32'hFFFF_FFFF};
    localparam logic [31:0] FCTL [16] = '{32'h0004_0100, 32'h0000_0100, 32'h8000_0000,
        32'h8000_0000, 32'h0004_0800, 32'h0, 32'h0004_0000, 32'h0005_0000, 32'h0008_0000,
        32'h0, 32'h0, 32'h0002_0000, 32'h0000_2000, 32'h0, 32'h0000_A000, 32'h0000_2000};
    // error, broadcast, multicast, perfect hit, hash hit, then filter and strip
    localparam logic [6:0] FCASE [16] = '{7'h03, 7'h00, 7'h02, 7'h40, 7'h20, 7'h22, 7'h40,
        7'h42, 7'h12, 7'h10, 7'h0A, 7'h08, 7'h16, 7'h14, 7'h06, 7'h04};
    logic sys_clk = 0, rst = 1, snap = 0, done_d = 0, carrier_busy = 0, coll_req = 0, tx_en = 0;
    logic buffer_command_we = 0, indirect_address_we = 0, indirect_data_we = 0, indirect_data_re = 0;
    logic [7:0] buffer_command_wdata = 0, indirect_address_wdata = 0, indirect_data_wdata = 0;
    logic rx_frame_done = 0, rx_frame_error = 0, rx_is_broadcast = 0, rx_is_multicast = 0;
    logic rx_perfect_hit = 0, rx_hash_hit = 0;
    logic [15:0] rx_length_field = 0;
    logic [7:0] buffer_command_reg, indirect_address_reg, indirect_data_reg;
    logic bit_time_tick, deferring, late_collision, rx_packet_filter, rx_strip_pad, rx_blocked;
    logic big_endian, codec_mode, heartbeat_enable, full_duplex, tx_allowed, late_collision_abort;
    logic defer_abort, rx_frame_accept, flush = 0;
    logic [1:0] loopback_select;
    logic [4:0] attempt_limit;
    logic [47:0] station_address, st_exp = 48'hFFFF_FFFF_FFFF;
    logic [31:0] seed = 32'h88E7_7E70;
    logic [63:0] exp_v, cfg_obs;
    logic [63:0] q[$];
    int n_fail = 0, n_tests = 0;

    ethernet_mac_csr_config #(.READ_LATENCY(2)) DUT (.sys_clk, .rst, .buffer_command_we,
        .buffer_command_wdata, .buffer_command_reg, .indirect_address_we, .indirect_address_wdata,
        .indirect_address_reg, .indirect_data_we, .indirect_data_re, .indirect_data_wdata,
        .indirect_data_reg, .rx_frame_done, .rx_frame_error, .rx_is_broadcast, .rx_is_multicast,
        .rx_perfect_hit, .rx_hash_hit, .rx_length_field, .flush_filter_fail(flush), .tx_en,
        .late_collision, .bit_time_tick, .deferring, .rx_packet_filter, .rx_frame_accept,
        .rx_strip_pad, .big_endian, .codec_mode, .heartbeat_enable, .rx_blocked, .loopback_select,
        .full_duplex, .tx_allowed, .rx_allowed(), .late_collision_abort, .attempt_limit,
        .backoff_slots(), .defer_abort, .station_address);
    phy_model u_phy (.sys_clk, .rst, .carrier_busy, .coll_req, .bit_time_tick, .deferring,
        .late_collision);

    assign cfg_obs = {1'b0, station_address, big_endian, codec_mode, heartbeat_enable,
        loopback_select, full_duplex, tx_allowed, attempt_limit, late_collision_abort, rx_blocked,
        defer_abort};

    initial forever #12.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict;
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic csr_write(input logic [7:0] a, input logic [31:0] d);
        for (int i = 3; i >= 0; i--) begin
            indirect_data_we <= 1;
            indirect_data_wdata <= d[8*i +: 8];
            @(posedge sys_clk);
        end
        indirect_data_we <= 0;
        indirect_address_we <= 1;
        indirect_address_wdata <= a;
        @(posedge sys_clk);
        indirect_address_we <= 0;
        buffer_command_we <= 1;
        buffer_command_wdata <= {4'h0, CMD_WRITE};
        @(posedge sys_clk);
        buffer_command_we <= 0;
    endtask

    // poke sends a write command while busy, which must be ignored
    task automatic csr_read(input logic [7:0] a, input logic [31:0] e, input logic poke);
        int k;
        indirect_address_we <= 1;
        indirect_address_wdata <= a;
        @(posedge sys_clk);
        indirect_address_we <= 0;
        buffer_command_we <= 1;
        buffer_command_wdata <= {4'h0, CMD_READ};
        @(posedge sys_clk);
        buffer_command_we <= poke;
        buffer_command_wdata <= {4'h0, CMD_WRITE};
        k = 0;
        do begin
            @(posedge sys_clk);
            buffer_command_we <= 0;
            k++;
        end while (buffer_command_reg[BUSY_BIT] !== 1'b0 && k < 40);
        if (k >= 40) n_fail++;
        for (int i = 3; i >= 0; i--) q.push_back({56'h0, e[8*i +: 8]});
        indirect_data_re <= 1;
        repeat (4) @(posedge sys_clk);
        indirect_data_re <= 0;
    endtask

    task automatic frame(input logic [4:0] f, input logic [15:0] len, input logic [2:0] e);
        {rx_frame_error, rx_is_broadcast, rx_is_multicast, rx_perfect_hit, rx_hash_hit} <= f;
        rx_length_field <= len;
        rx_frame_done <= 1;
        q.push_back({61'h0, e});
        @(posedge sys_clk);
        rx_frame_done <= 0;
        @(posedge sys_clk);
    endtask

    task automatic check_cfg(input logic [14:0] e);
        q.push_back({1'b0, st_exp, e});
        snap <= 1;
        @(posedge sys_clk);
        snap <= 0;
    endtask

    always @(posedge sys_clk) begin
        done_d <= rx_frame_done;
        if (indirect_data_re) `CHK({56'h0, indirect_data_reg}, q.pop_front())
        if (done_d) `CHK({61'h0, rx_frame_accept, rx_packet_filter, rx_strip_pad},
            q.pop_front())
        if (snap) `CHK(cfg_obs, q.pop_front())
    end

    initial begin
        #2_000_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        csr_read(ADDR_MAC_CONTROL, MAC_CONTROL_RESET, 0);
        csr_read(ADDR_STATION_HIGH, STATION_HIGH_RESET, 1);
        csr_read(ADDR_STATION_LOW, STATION_LOW_RESET, 0);
        check_cfg({3'b001, 4'h0, ATTEMPTS_NORMAL, 3'b000});
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            csr_write(8'(4 * (i % 3)), seed);
            csr_read(8'(4 * (i % 3)), seed & RMASK[i % 3], i == 4);
            if (i % 3 == 1) st_exp[47:32] = seed[15:0];
            if (i % 3 == 2) st_exp[31:0] = seed;
        end
        csr_write(8'h0C, seed);
        csr_read(8'h0C, 32'h0, 0);
        tx_en <= 1;
        coll_req <= 1;
        for (int j = 0; j < 3; j++) begin
            seed = 32'h1000_0000 | (j & 1) * 32'h4010_1000 | (j >> 1) * 32'h0800_0408;
            csr_write(ADDR_MAC_CONTROL, seed | j * 32'h0020_0000 | (j == 0) * 32'h0080_0000);
            check_cfg({j[0], j[1], !j[1], j[1:0], j[0], j[1],
                j[1] ? ATTEMPTS_NO_RETRY : ATTEMPTS_NORMAL, !j[0], j == 0, 1'b0});
        end
        tx_en <= 0;
        coll_req <= 0;
        csr_write(ADDR_MAC_CONTROL, 32'h0000_0020);
        carrier_busy <= 1;
        repeat (24000) @(posedge sys_clk);
        check_cfg({3'b001, 4'h0, ATTEMPTS_NORMAL, 3'b000});
        repeat (400) @(posedge sys_clk);
        check_cfg({3'b001, 4'h0, ATTEMPTS_NORMAL, 3'b001});
        carrier_busy <= 0;
        flush <= 1;
        for (int i = 0; i < 16; i++) begin
            csr_write(ADDR_MAC_CONTROL, FCTL[i]);
            frame(FCASE[i][6:2], FCASE[i][0] ? 16'h0014 : 16'h002E,
                {FCASE[i][1] | FCTL[i][31], FCASE[i][1:0]});
        end
        repeat (4) @(posedge sys_clk);
        `CHK(64'(q.size()), 64'h0)
        give_verdict();
    end
endmodule // tb
`default_nettype wire
